// ### gpa_ports.sv
`timescale 1ns/100ps
// Function
// - second port has eight bidirectional latched pins
// - second direction bit one means input, resets ones
// - clearing option bit seven enables pull-ups on all second input pins
// - output-configured second pins never get pull-up
// - pull-ups off after reset, options reset ones
// - only upper four input pins detect change
// - compare pins against copy from last access
// - ORed mismatches set port change flag bit0
// - pending port change flag wakes sleeping device
// - any second port access refreshes comparison copy
// - mismatch keeps setting flag; read then clear
// - second bit zero feeds external interrupt input
// - second bits six, seven give programming lines
// - first bit four is timer clock, open-drain
// - first bit five gives serial slave select
// - first port six bits, upper read zero
// - analog pin config resets to zero always
// - analog variant first reads zero except bit4
// - third port six pins, own direction bits
// - enabled peripherals override third direction bits
// - data read returns pins, write loads latch
// - first direction bit one means high impedance
module gpa_ports #(
  parameter int ADDR_W = 10,
  parameter bit ANALOG_VARIANT = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [5:0] first_port_in,
  input wire logic [7:0] second_port_in,
  input wire logic [5:0] third_port_in,
  output gpa_pkg::gpa_drive_type first_port_drive,
  output gpa_pkg::gpa_drive_type second_port_drive,
  output gpa_pkg::gpa_drive_type third_port_drive,
  output logic [7:0] second_port_pullup,
  input wire logic [5:0] periph_dir_ovr_en,
  input wire logic [5:0] periph_dir_ovr_val,
  output logic port_change_wake,
  output logic ext_interrupt,
  output logic prog_clock,
  output logic prog_data,
  output logic timer_clock,
  output logic slave_select_b
);

  if (ADDR_W < 10) begin : g_chk
    $error("gpa_ports: ADDR_W must be at least 10");
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [5:0] first_latch_q;
  logic [7:0] second_latch_q;
  logic [5:0] third_latch_q;
  logic [5:0] first_dir_q;
  logic [7:0] second_dir_q;
  logic [5:0] third_dir_q;
  logic [7:0] options_q;
  logic [2:0] analog_cfg_q;
  logic port_change_flag_q;
  logic [3:0] change_copy_q;
  logic [7:0] idx;
  logic commit;
  logic wr_commit;
  logic [3:0] mismatch;
  logic [5:0] analog_mask;
  logic [5:0] third_dir_eff;

  function automatic logic [5:0] analog_pins(input logic [2:0] cfg);
    unique case (cfg)
      gpa_pkg::ACFG_ALL: analog_pins = gpa_pkg::AMASK_ALL;
      gpa_pkg::ACFG_LOW4: analog_pins = gpa_pkg::AMASK_LOW4;
      gpa_pkg::ACFG_LOW2: analog_pins = gpa_pkg::AMASK_LOW2;
      default: analog_pins = gpa_pkg::AMASK_NONE;
    endcase
  endfunction

  assign idx = avs_address[9:2];
  // an access takes effect only at the edge where waitrequest is seen low
  assign commit = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_commit = avs_write & ~avs_waitrequest;
  assign analog_mask = ANALOG_VARIANT ? analog_pins(analog_cfg_q) : gpa_pkg::AMASK_NONE;
  // input-only pins in the upper nibble take part
  assign mismatch = (second_port_in[7:4] ^ change_copy_q) & second_dir_q[7:4];
  assign third_dir_eff = (third_dir_q & ~periph_dir_ovr_en)
                       | (periph_dir_ovr_val & periph_dir_ovr_en);

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the answer

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // read data is sampled in the wait cycle and held through the answer edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= 32'h0000_0000;
      unique case (idx)
        gpa_pkg::IDX_FIRST_DATA: avs_readdata[5:0] <= first_port_in & ~analog_mask;
        gpa_pkg::IDX_SECOND_DATA: avs_readdata[7:0] <= second_port_in;
        gpa_pkg::IDX_THIRD_DATA: avs_readdata[5:0] <= third_port_in;
        gpa_pkg::IDX_INT_CTRL: avs_readdata[gpa_pkg::INT_PORT_CHANGE] <= port_change_flag_q;
        gpa_pkg::IDX_OPTIONS: avs_readdata[7:0] <= options_q;
        gpa_pkg::IDX_FIRST_DIR: avs_readdata[5:0] <= first_dir_q;
        gpa_pkg::IDX_SECOND_DIR: avs_readdata[7:0] <= second_dir_q;
        gpa_pkg::IDX_THIRD_DIR: avs_readdata[5:0] <= third_dir_eff;
        gpa_pkg::IDX_ANALOG_CFG: avs_readdata[2:0] <= ANALOG_VARIANT ? analog_cfg_q : 3'h0;
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output latches

  // a full-byte write leaves nothing to merge, so it equals read-modify-write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_latch_q <= 6'h00;
      second_latch_q <= 8'h00;
      third_latch_q <= 6'h00;
    end else if (wr_commit) begin
      if (idx == gpa_pkg::IDX_FIRST_DATA) begin
        first_latch_q <= avs_writedata[5:0];
      end
      if (idx == gpa_pkg::IDX_SECOND_DATA) begin
        second_latch_q <= avs_writedata[7:0];
      end
      if (idx == gpa_pkg::IDX_THIRD_DATA) begin
        third_latch_q <= avs_writedata[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // direction, options and analog config

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_dir_q <= gpa_pkg::RST_FIRST_DIR;
      second_dir_q <= gpa_pkg::RST_SECOND_DIR;
      third_dir_q <= gpa_pkg::RST_THIRD_DIR;
    end else if (wr_commit) begin
      if (idx == gpa_pkg::IDX_FIRST_DIR) begin
        first_dir_q <= avs_writedata[5:0];
      end
      if (idx == gpa_pkg::IDX_SECOND_DIR) begin
        second_dir_q <= avs_writedata[7:0];
      end
      if (idx == gpa_pkg::IDX_THIRD_DIR) begin
        third_dir_q <= avs_writedata[5:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      options_q <= gpa_pkg::RST_OPTIONS;
      analog_cfg_q <= gpa_pkg::RST_ANALOG_CFG;
    end else if (wr_commit) begin
      if (idx == gpa_pkg::IDX_OPTIONS) begin
        options_q <= avs_writedata[7:0];
      end
      if (idx == gpa_pkg::IDX_ANALOG_CFG) begin
        analog_cfg_q <= avs_writedata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // change detection

  // reads and writes alike refresh the copy, so polling ends a mismatch but a set flag stays
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      change_copy_q <= 4'h0;
    end else if (commit && idx == gpa_pkg::IDX_SECOND_DATA) begin
      // a read keeps what software saw, so a change inside the wait cycle still flags
      if (avs_read) begin
        change_copy_q <= avs_readdata[7:gpa_pkg::CHG_LO];
      end else begin
        change_copy_q <= second_port_in[7:gpa_pkg::CHG_LO];
      end
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_change_flag_q <= 1'b0;
    end else if (|mismatch) begin
      port_change_flag_q <= 1'b1;
    end else if (wr_commit && idx == gpa_pkg::IDX_INT_CTRL
                 && !avs_writedata[gpa_pkg::INT_PORT_CHANGE]) begin
      port_change_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers, all from flops

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_port_drive <= '0;
      second_port_drive <= '0;
      third_port_drive <= '0;
    end else begin
      first_port_drive.out <= {2'h0, first_latch_q};
      first_port_drive.oe <= {2'h0, ~first_dir_q};
      // open-drain: drive low only when the latch holds zero
      first_port_drive.out[gpa_pkg::FIRST_TIMER_CLK] <= 1'b0;
      first_port_drive.oe[gpa_pkg::FIRST_TIMER_CLK] <=
        ~first_dir_q[gpa_pkg::FIRST_TIMER_CLK] & ~first_latch_q[gpa_pkg::FIRST_TIMER_CLK];
      second_port_drive.out <= second_latch_q;
      second_port_drive.oe <= ~second_dir_q;
      third_port_drive.out <= {2'h0, third_latch_q};
      third_port_drive.oe <= {2'h0, ~third_dir_eff};
    end
  end

  // pull-ups only on inputs, and only while the control bit is clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      second_port_pullup <= 8'h00;
    end else begin
      second_port_pullup <= options_q[gpa_pkg::OPT_PULLUP_DIS_N] ? 8'h00 : second_dir_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alternate functions; thresholds are pad matters, logic sees levels

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_change_wake <= 1'b0;
      ext_interrupt <= 1'b0;
      prog_clock <= 1'b0;
      prog_data <= 1'b0;
      timer_clock <= 1'b0;
      slave_select_b <= 1'b1;
    end else begin
      port_change_wake <= port_change_flag_q;
      ext_interrupt <= second_port_in[gpa_pkg::SECOND_EXT_INT];
      prog_clock <= second_port_in[gpa_pkg::SECOND_PROG_CLK];
      prog_data <= second_port_in[gpa_pkg::SECOND_PROG_DATA];
      timer_clock <= first_port_in[gpa_pkg::FIRST_TIMER_CLK];
      slave_select_b <= first_port_in[gpa_pkg::FIRST_SLAVE_SEL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  second_hiz_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ##1 ((second_port_drive.oe & $past(second_dir_q)) == 8'h00))
    else $error("second port drives an input pin");

  pullup_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ##1 ((second_port_pullup & ~$past(second_dir_q)) == 8'h00))
    else $error("pull-up on an output pin");

  pullup_on_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !options_q[gpa_pkg::OPT_PULLUP_DIS_N] |=> second_port_pullup == $past(second_dir_q))
    else $error("pull-ups not enabled");

  change_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (|mismatch) |=> port_change_flag_q ##1 port_change_wake)
    else $error("mismatch did not set flag and wake");

  outputs_excluded_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (second_dir_q[7:4] == 4'h0 && !port_change_flag_q) |=> !port_change_flag_q)
    else $error("output pins raised the change flag");

  copy_refresh_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (commit && avs_write && idx == gpa_pkg::IDX_SECOND_DATA)
    |=> change_copy_q == $past(second_port_in[7:gpa_pkg::CHG_LO]))
    else $error("comparison copy not refreshed");

  flag_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (port_change_flag_q && !(wr_commit && idx == gpa_pkg::IDX_INT_CTRL)) |=> port_change_flag_q)
    else $error("change flag dropped without a clear");

  open_drain_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    first_port_drive.out[gpa_pkg::FIRST_TIMER_CLK] == 1'b0)
    else $error("timer clock pin drives high");

  first_upper_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (avs_read && !avs_waitrequest && $past(idx) == gpa_pkg::IDX_FIRST_DATA)
    |-> avs_readdata[31:6] == 26'h0)
    else $error("first port upper bits not zero");

  override_dir_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |-> ((third_port_drive.oe[5:0] & $past(periph_dir_ovr_en))
         == (~$past(periph_dir_ovr_val) & $past(periph_dir_ovr_en))))
    else $error("peripheral direction override ignored");

  bus_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ((avs_read || avs_write) && avs_waitrequest) |-> ##[1:2] !avs_waitrequest)
    else $error("bus request not answered");

  bus_stand_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  // $past(rst_b) skips the edge where the flops still sat in reset
  copy_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (commit && avs_read && idx == gpa_pkg::IDX_SECOND_DATA)
    |=> change_copy_q == $past(avs_readdata[7:gpa_pkg::CHG_LO]))
    else $error("copy differs from the value read");

  flag_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wr_commit && idx == gpa_pkg::IDX_INT_CTRL && !avs_writedata[gpa_pkg::INT_PORT_CHANGE]
     && !(|mismatch)) |=> !port_change_flag_q)
    else $error("change flag not cleared");

  wake_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |-> port_change_wake == $past(port_change_flag_q))
    else $error("wake does not follow the change flag");

  ext_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |-> ext_interrupt == $past(second_port_in[gpa_pkg::SECOND_EXT_INT]))
    else $error("external interrupt input not passed on");

  prog_pins_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |-> {prog_data, prog_clock}
      == $past(second_port_in[gpa_pkg::SECOND_PROG_DATA:gpa_pkg::SECOND_PROG_CLK]))
    else $error("programming lines not passed on");

  timer_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |-> timer_clock == $past(first_port_in[gpa_pkg::FIRST_TIMER_CLK]))
    else $error("timer clock input not passed on");

  slave_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |-> slave_select_b == $past(first_port_in[gpa_pkg::FIRST_SLAVE_SEL]))
    else $error("slave select input not passed on");

  first_hiz_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |-> (first_port_drive.oe[5:0] & $past(first_dir_q)) == 6'h00)
    else $error("first port drives an input pin");

  second_out_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |-> second_port_drive.out == $past(second_latch_q))
    else $error("second port output differs from latch");

  third_out_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |-> third_port_drive.out == {2'h0, $past(third_latch_q)})
    else $error("third port output differs from latch");

  pullup_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    options_q[gpa_pkg::OPT_PULLUP_DIS_N] |=> second_port_pullup == 8'h00)
    else $error("pull-up on while disabled");

  upper_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (first_port_drive.oe[7:6] | third_port_drive.oe[7:6]) == 2'h0)
    else $error("unimplemented pin driven");

  analog_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (avs_read && !avs_waitrequest && $past(idx) == gpa_pkg::IDX_FIRST_DATA
     && $past(analog_mask) == gpa_pkg::AMASK_ALL)
    |-> (avs_readdata[5:0] & gpa_pkg::AMASK_ALL) == 6'h00)
    else $error("analog pin read not zero");

endmodule // gpa_ports

// ### gpa_pkg.sv
package gpa_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FIRST_DATA = 8'h05;
  localparam logic [7:0] IDX_SECOND_DATA = 8'h06;
  localparam logic [7:0] IDX_THIRD_DATA = 8'h07;
  localparam logic [7:0] IDX_INT_CTRL = 8'h0B;
  localparam logic [7:0] IDX_OPTIONS = 8'h81;
  localparam logic [7:0] IDX_FIRST_DIR = 8'h85;
  localparam logic [7:0] IDX_SECOND_DIR = 8'h86;
  localparam logic [7:0] IDX_THIRD_DIR = 8'h87;
  localparam logic [7:0] IDX_ANALOG_CFG = 8'h9F;

  // reset values
  localparam logic [7:0] RST_OPTIONS = 8'hFF;
  localparam logic [5:0] RST_FIRST_DIR = 6'h3F;
  localparam logic [7:0] RST_SECOND_DIR = 8'hFF;
  localparam logic [5:0] RST_THIRD_DIR = 6'h3F;
  localparam logic [2:0] RST_ANALOG_CFG = 3'h0;

  // field positions
  localparam int OPT_PULLUP_DIS_N = 7;
  localparam int INT_PORT_CHANGE = 0;
  localparam int FIRST_TIMER_CLK = 4;
  localparam int FIRST_SLAVE_SEL = 5;
  localparam int SECOND_EXT_INT = 0;
  localparam int SECOND_PROG_CLK = 6;
  localparam int SECOND_PROG_DATA = 7;
  localparam int CHG_LO = 4;

  // analog pin select codes and the first-port pins they make analog
  localparam logic [2:0] ACFG_ALL = 3'h0;
  localparam logic [2:0] ACFG_LOW4 = 3'h1;
  localparam logic [2:0] ACFG_LOW2 = 3'h2;
  localparam logic [5:0] AMASK_ALL = 6'h2F;
  localparam logic [5:0] AMASK_LOW4 = 6'h0F;
  localparam logic [5:0] AMASK_LOW2 = 6'h03;
  localparam logic [5:0] AMASK_NONE = 6'h00;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpa_drive_type;

endpackage

// ### gpa_board.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// board side of one port: keypad drivers, weak pull-ups, else a floating line
module gpa_board (
  input wire logic ref_clk,
  input wire gpa_pkg::gpa_drive_type drive,
  input wire logic [7:0] pull,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin
);
  logic [7:0] float_q = 8'h55;
  // a floating line must not look stable, so it changes every cycle
  always @(posedge ref_clk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drive.oe[i]) begin
        pin[i] = drive.out[i];
      end else if (ext_en[i]) begin
        pin[i] = ext_val[i];
      end else if (pull[i]) begin
        pin[i] = 1'b1;
      end else begin
        pin[i] = float_q[i];
      end
    end
  end
endmodule // gpa_board

// ### tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module tb;
  logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest, port_change_wake;
  logic ext_interrupt, prog_clock, prog_data, timer_clock, slave_select_b;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [5:0] ovr_en, ovr_val;
  logic [7:0] pin_a, pin_b, pin_c, pull_b, en_a, en_b, en_c, val_a, val_b, val_c, seed, v;
  gpa_pkg::gpa_drive_type drv_a, drv_b, drv_c;
  int bad_count, check_count, cycles;
  //////////////////////////////////////////////////////////////////////////////
  gpa_ports i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .first_port_in(pin_a[5:0]), .second_port_in(pin_b), .third_port_in(pin_c[5:0]),
    .first_port_drive(drv_a), .second_port_drive(drv_b), .third_port_drive(drv_c),
    .second_port_pullup(pull_b), .periph_dir_ovr_en(ovr_en), .periph_dir_ovr_val(ovr_val),
    .port_change_wake(port_change_wake), .ext_interrupt(ext_interrupt),
    .prog_clock(prog_clock), .prog_data(prog_data), .timer_clock(timer_clock),
    .slave_select_b(slave_select_b));
  gpa_board i_brd_a (.ref_clk(ref_clk), .drive(drv_a), .pull(8'h00), .ext_en(en_a),
    .ext_val(val_a), .pin(pin_a));
  gpa_board i_brd_b (.ref_clk(ref_clk), .drive(drv_b), .pull(pull_b), .ext_en(en_b),
    .ext_val(val_b), .pin(pin_b));
  gpa_board i_brd_c (.ref_clk(ref_clk), .drive(drv_c), .pull(8'h00), .ext_en(en_c),
    .ext_val(val_c), .pin(pin_c));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // analog pins read zero; bit4 is never analog
  function automatic logic [7:0] afirst(input logic [2:0] cfg, input logic [7:0] p);
    logic [5:0] m;
    m = (cfg == gpa_pkg::ACFG_ALL) ? gpa_pkg::AMASK_ALL :
        (cfg == gpa_pkg::ACFG_LOW4) ? gpa_pkg::AMASK_LOW4 :
        (cfg == gpa_pkg::ACFG_LOW2) ? gpa_pkg::AMASK_LOW2 : gpa_pkg::AMASK_NONE;
    return {2'h0, p[5:0] & ~m};
  endfunction
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge ref_clk);
    avs_address <= {idx, 2'h0};
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    // no limit here: a hang runs into the cycle ceiling and fails there
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    `CHK("readdata", {24'h0, e}, rd)
  endtask
  // drive outputs lag the register by one edge; let them land first
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, ovr_en, ovr_val} = '0;
    {en_a, en_b, en_c, val_a, val_b, val_c} = '0;
    seed = 8'h5A;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdc(gpa_pkg::IDX_OPTIONS, 8'hFF);
    rdc(gpa_pkg::IDX_FIRST_DIR, 8'h3F);
    rdc(gpa_pkg::IDX_SECOND_DIR, 8'hFF);
    rdc(gpa_pkg::IDX_THIRD_DIR, 8'h3F);
    rdc(gpa_pkg::IDX_ANALOG_CFG, 8'h00);
    rdc(8'h40, 8'h00);
    `CHK("pullup", 8'h00, pull_b)
    `CHK("second oe", 8'h00, drv_b.oe)
    seed = lfsr(seed);
    bus(1'b1, gpa_pkg::IDX_SECOND_DATA, seed);
    bus(1'b1, gpa_pkg::IDX_SECOND_DIR, 8'hF0);
    bus(1'b1, gpa_pkg::IDX_OPTIONS, 8'h7F);
    settle();
    `CHK("second oe", 8'h0F, drv_b.oe)
    `CHK("second out", seed, drv_b.out)
    `CHK("pullup", 8'hF0, pull_b)
    bus(1'b1, gpa_pkg::IDX_OPTIONS, 8'hFF);
    bus(1'b1, gpa_pkg::IDX_SECOND_DIR, 8'hFF);
    settle();
    `CHK("pullup", 8'h00, pull_b)
    // open-drain pin only ever pulls low
    bus(1'b1, gpa_pkg::IDX_FIRST_DATA, 8'h00);
    bus(1'b1, gpa_pkg::IDX_FIRST_DIR, 8'h2F);
    settle();
    `CHK("first oe", 8'h10, drv_a.oe)
    `CHK("first out", 8'h00, drv_a.out)
    bus(1'b1, gpa_pkg::IDX_FIRST_DATA, 8'h3F);
    bus(1'b1, gpa_pkg::IDX_FIRST_DIR, 8'h00);
    settle();
    `CHK("first oe", 8'h2F, drv_a.oe)
    `CHK("first out", 8'h2F, drv_a.out)
    bus(1'b1, gpa_pkg::IDX_FIRST_DIR, 8'hFF);
    rdc(gpa_pkg::IDX_FIRST_DIR, 8'h3F);
    en_a <= 8'hFF;
    en_c <= 8'hFF;
    en_b <= 8'hFF;
    for (int c = 0; c < 4; c++) begin
      seed = lfsr(seed);
      val_a <= seed;
      bus(1'b1, gpa_pkg::IDX_ANALOG_CFG, 8'(c));
      rdc(gpa_pkg::IDX_FIRST_DATA, afirst(3'(c), seed));
      settle();
      `CHK("timer clock", seed[4], timer_clock)
      `CHK("slave select", seed[5], slave_select_b)
    end
    seed = lfsr(seed);
    val_c <= seed;
    rdc(gpa_pkg::IDX_THIRD_DATA, seed & 8'h3F);
    bus(1'b1, gpa_pkg::IDX_THIRD_DATA, ~seed);
    bus(1'b1, gpa_pkg::IDX_THIRD_DIR, 8'h00);
    ovr_en <= 6'h03;
    ovr_val <= 6'h01;
    settle();
    `CHK("third oe", 8'h3E, drv_c.oe)
    `CHK("third out", ~seed & 8'h3F, drv_c.out)
    rdc(gpa_pkg::IDX_THIRD_DIR, 8'h01);
    ovr_en <= 6'h00;
    settle();
    `CHK("third oe", 8'h3F, drv_c.oe)
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v = seed;
      val_b <= v;
      rdc(gpa_pkg::IDX_SECOND_DATA, v);
      bus(1'b1, gpa_pkg::IDX_INT_CTRL, 8'h00);
      rdc(gpa_pkg::IDX_INT_CTRL, 8'h00);
      `CHK("ext int", v[0], ext_interrupt)
      `CHK("prog lines", v[7:6], {prog_data, prog_clock})
      val_b <= v ^ 8'h0F;
      settle();
      rdc(gpa_pkg::IDX_INT_CTRL, 8'h00);
      val_b <= v ^ 8'h0F ^ 8'(8'h10 << i);
      settle();
      `CHK("wake", 1'b1, port_change_wake)
      rdc(gpa_pkg::IDX_INT_CTRL, 8'h01);
      bus(1'b1, gpa_pkg::IDX_INT_CTRL, 8'h00);
      rdc(gpa_pkg::IDX_INT_CTRL, 8'h01);
      bus(i[0], gpa_pkg::IDX_SECOND_DATA, v);
      bus(1'b1, gpa_pkg::IDX_INT_CTRL, 8'h00);
      rdc(gpa_pkg::IDX_INT_CTRL, 8'h00);
    end
    // second reset in mid-run: written registers must fall back
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdc(gpa_pkg::IDX_ANALOG_CFG, 8'h00);
    rdc(gpa_pkg::IDX_THIRD_DIR, 8'h3F);
    rdc(gpa_pkg::IDX_OPTIONS, 8'hFF);
    `CHK("pullup", 8'h00, pull_b)
    results();
  end
endmodule // tb
